// [logic/spt_timer.v]
// Self polling on/off timer with AHB-Lite register slave.
// Assumes a single AHB-Lite master, single word transfers, sys_clk domain only.
//
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`include "spt_consts.vh"

module spt_timer #(
    parameter CW = `SPT_COUNT_W
) (
    // Clock and reset
    input  wire        sys_clk,
    input  wire        rst,
    // AHB-Lite slave
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    // Phase outputs
    output reg         listen_on,
    output reg         ref_tick,
    output reg         phase_end
);

    localparam ST_IDLE   = 2'd0;
    localparam ST_SLEEP  = 2'd1;
    localparam ST_LISTEN = 2'd2;

    // Sized copies of the header constants
    localparam [31:0] PRE_LAST_W = `SPT_PRESCALE - 1;
    localparam [7:0]  RST_HIGH_W = `SPT_RST_HIGH;
    localparam [7:0]  RST_CTRL_W = `SPT_RST_CTRL;
    localparam [5:0]  PRE_LAST   = PRE_LAST_W[5:0];
    localparam [5:0]  RST_HIGH   = RST_HIGH_W[5:0];
    localparam [1:0]  RST_CTRL   = RST_CTRL_W[1:0];

    reg  [7:0]    sleep_phase_count_low_ff;
    reg  [5:0]    sleep_phase_count_high_ff;
    reg  [7:0]    listen_count_cfg_a_low_ff;
    reg  [5:0]    listen_count_cfg_a_high_ff;
    reg  [7:0]    listen_count_cfg_b_low_ff;
    reg  [5:0]    listen_count_cfg_b_high_ff;
    reg  [7:0]    reference_divider_value_ff;
    reg  [1:0]    ctrl_ff;
    reg           wr_pend_ff;
    reg  [7:0]    wr_idx_ff;
    reg  [5:0]    pre_ff;
    reg  [7:0]    div_ff;
    reg  [1:0]    state_ff;
    reg  [CW:0]   cnt_ff;
    reg  [1:0]    nxt_state;
    reg  [CW:0]   nxt_cnt;
    reg           nxt_end;
    reg  [31:0]   nxt_rdata;

    wire [CW-1:0] sleep_phase_count  = {sleep_phase_count_high_ff,
                                        sleep_phase_count_low_ff};
    wire [CW-1:0] listen_count_cfg_a = {listen_count_cfg_a_high_ff,
                                        listen_count_cfg_a_low_ff};
    wire [CW-1:0] listen_count_cfg_b = {listen_count_cfg_b_high_ff,
                                        listen_count_cfg_b_low_ff};
    wire          addr_ph = hsel && hready && htrans[1];
    wire [7:0]    a_idx   = haddr[9:2];
    wire          pre_tc  = (pre_ff == PRE_LAST);
    // Lowering the divider below the running count waits for one wrap
    wire [7:0]    div_max = reference_divider_value_ff - 8'h01;

    // Zero count stands for the full 2^14 ticks
    function [CW:0] phase_len;
        input [CW-1:0] v;
        begin
            phase_len = (v == {CW{1'b0}}) ? {1'b1, {CW{1'b0}}} : {1'b0, v};
        end
    endfunction

    // Reference tick: divide by 64, then by divider value (0 wraps to 256)
    // Prescaler free-runs, so the first tick after enabling may come early
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pre_ff   <= 6'h00;
            div_ff   <= 8'h00;
            ref_tick <= 1'b0;
        end else begin
            pre_ff   <= pre_ff + 6'h01;
            ref_tick <= 1'b0;
            if (pre_tc) begin
                if (div_ff == div_max) begin
                    div_ff   <= 8'h00;
                    ref_tick <= 1'b1;
                end else begin
                    div_ff <= div_ff + 8'h01;
                end
            end
        end
    end

    // Phase sequencer
    always @* begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        nxt_end   = 1'b0;
        case (state_ff)
            ST_IDLE: begin
                if (ctrl_ff[`SPT_CTRL_EN]) begin
                    nxt_state = ST_SLEEP;
                    nxt_cnt   = phase_len(sleep_phase_count);
                end
            end
            // Clearing enable returns to idle at once
            ST_SLEEP, ST_LISTEN: begin
                if (!ctrl_ff[`SPT_CTRL_EN]) begin
                    nxt_state = ST_IDLE;
                end else if (ref_tick) begin
                    if (cnt_ff == {{CW{1'b0}}, 1'b1}) begin
                        nxt_end = 1'b1;
                        if (state_ff == ST_SLEEP) begin
                            nxt_state = ST_LISTEN;
                            nxt_cnt   = ctrl_ff[`SPT_CTRL_CFG_B] ?
                                        phase_len(listen_count_cfg_b) :
                                        phase_len(listen_count_cfg_a);
                        end else begin
                            nxt_state = ST_SLEEP;
                            nxt_cnt   = phase_len(sleep_phase_count);
                        end
                    end else begin
                        nxt_cnt = cnt_ff - {{CW{1'b0}}, 1'b1};
                    end
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    // Registered phase outputs
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_ff  <= ST_IDLE;
            cnt_ff    <= {(CW+1){1'b0}};
            listen_on <= 1'b0;
            phase_end <= 1'b0;
        end else begin
            state_ff  <= nxt_state;
            cnt_ff    <= nxt_cnt;
            listen_on <= (nxt_state == ST_LISTEN);
            phase_end <= nxt_end;
        end
    end

    // Read data mux
    always @* begin
        nxt_rdata = 32'h0000_0000;
        case (a_idx)
            `SPT_IDX_SLEEP_LOW:     nxt_rdata[7:0] = sleep_phase_count_low_ff;
            `SPT_IDX_SLEEP_HIGH:    nxt_rdata[5:0] = sleep_phase_count_high_ff;
            `SPT_IDX_LISTEN_A_LOW:  nxt_rdata[7:0] = listen_count_cfg_a_low_ff;
            `SPT_IDX_LISTEN_A_HIGH: nxt_rdata[5:0] = listen_count_cfg_a_high_ff;
            `SPT_IDX_LISTEN_B_LOW:  nxt_rdata[7:0] = listen_count_cfg_b_low_ff;
            `SPT_IDX_LISTEN_B_HIGH: nxt_rdata[5:0] = listen_count_cfg_b_high_ff;
            `SPT_IDX_REF_DIV:       nxt_rdata[7:0] = reference_divider_value_ff;
            `SPT_IDX_CTRL:          nxt_rdata[1:0] = ctrl_ff;
            // Status: state above the live phase count
            `SPT_IDX_STATUS:        nxt_rdata      = {{(29-CW){1'b0}}, state_ff, cnt_ff};
            default:                nxt_rdata      = 32'h0000_0000;
        endcase
    end

    // AHB-Lite slave: zero wait states, always OKAY
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            hrdata                     <= 32'h0000_0000;
            hreadyout                  <= 1'b1;
            hresp                      <= 1'b0;
            wr_pend_ff                 <= 1'b0;
            wr_idx_ff                  <= 8'h00;
            sleep_phase_count_low_ff   <= `SPT_RST_LOW;
            sleep_phase_count_high_ff  <= RST_HIGH;
            listen_count_cfg_a_low_ff  <= `SPT_RST_LOW;
            listen_count_cfg_a_high_ff <= RST_HIGH;
            listen_count_cfg_b_low_ff  <= `SPT_RST_LOW;
            listen_count_cfg_b_high_ff <= RST_HIGH;
            reference_divider_value_ff <= `SPT_RST_REF_DIV;
            ctrl_ff                    <= RST_CTRL;
        end else begin
            // Write data follows its address phase by one cycle
            wr_pend_ff <= addr_ph && hwrite;
            wr_idx_ff  <= a_idx;
            // Read data is loaded in the address phase and stands until the next read
            if (addr_ph && !hwrite) begin
                hrdata <= nxt_rdata;
            end
            if (wr_pend_ff) begin
                case (wr_idx_ff)
                    `SPT_IDX_SLEEP_LOW:     sleep_phase_count_low_ff   <= hwdata[7:0];
                    `SPT_IDX_SLEEP_HIGH:    sleep_phase_count_high_ff  <= hwdata[5:0];
                    `SPT_IDX_LISTEN_A_LOW:  listen_count_cfg_a_low_ff  <= hwdata[7:0];
                    `SPT_IDX_LISTEN_A_HIGH: listen_count_cfg_a_high_ff <= hwdata[5:0];
                    `SPT_IDX_LISTEN_B_LOW:  listen_count_cfg_b_low_ff  <= hwdata[7:0];
                    `SPT_IDX_LISTEN_B_HIGH: listen_count_cfg_b_high_ff <= hwdata[5:0];
                    `SPT_IDX_REF_DIV:       reference_divider_value_ff <= hwdata[7:0];
                    `SPT_IDX_CTRL:          ctrl_ff                    <= hwdata[1:0];
                    default:                ctrl_ff                    <= ctrl_ff;
                endcase
            end
        end
    end

endmodule // spt_timer

// [logic/spt_consts.vh]
// Constants for the self polling on/off timer block.
// Assumes inclusion by bare name from the design files.
`ifndef SPT_CONSTS_VH
`define SPT_CONSTS_VH

// Register indices: the byte address is four times the index
`define SPT_IDX_SLEEP_LOW     8'h9a
`define SPT_IDX_SLEEP_HIGH    8'h9b
`define SPT_IDX_LISTEN_A_LOW  8'h9c
`define SPT_IDX_LISTEN_A_HIGH 8'h9d
`define SPT_IDX_LISTEN_B_LOW  8'h9e
`define SPT_IDX_LISTEN_B_HIGH 8'h9f
// Extra registers: divider value, control, status
`define SPT_IDX_REF_DIV       8'h99
`define SPT_IDX_CTRL          8'ha0
`define SPT_IDX_STATUS        8'ha1

// Reset values
`define SPT_RST_LOW           8'h01
`define SPT_RST_HIGH          8'h00
`define SPT_RST_REF_DIV       8'h01
`define SPT_RST_CTRL          8'h00

// Field positions
`define SPT_HIGH_MSB          5
`define SPT_CTRL_EN           0
`define SPT_CTRL_CFG_B        1

// Timing
`define SPT_PRESCALE          64
`define SPT_COUNT_W           14

`endif

// [verif/spt_timer_asserts.sv]
// Port checker for the self polling on/off timer.
// Assumes binding to spt_timer with a single AHB-Lite master.
`timescale 1ns/100ps
module spt_timer_asserts #(
    parameter CW = 14
) (
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        rst,
    // Bus
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // Phase outputs
    input wire logic        listen_on,
    input wire logic        ref_tick,
    input wire logic        phase_end
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    wire rd_take = hsel && hready && htrans[1] && !hwrite;

    a_resp_okay: assert property (hresp == 1'b0) else $error("hresp not okay");
    a_ready_high: assert property (hreadyout) else $error("hreadyout low");
    a_read_hold: assert property (!rd_take |=> $stable(hrdata)) else $error("hrdata moved");
    a_upper_zero: assert property (hrdata[31:17] == 15'h0) else $error("hrdata upper set");
    a_tick_gap: assert property (ref_tick |=> !ref_tick [*8])
        else $error("ref_tick too close");
    a_end_gap: assert property (phase_end |=> !phase_end [*8])
        else $error("phase_end too close");
    a_listen_rise: assert property ($rose(listen_on) |-> phase_end)
        else $error("listen began without phase end");
    a_end_on_tick: assert property (phase_end |-> $past(ref_tick))
        else $error("phase end without a tick");
    a_reset_idle: assert property ($fell(rst) |-> !listen_on && !phase_end && !ref_tick)
        else $error("outputs active after reset");
endmodule // spt_timer_asserts

// [verif/test_spt_timer.sv]
// Self-checking bench for the self polling on/off timer.
// Assumes spt_timer is the only bus slave; hready is fed back from hreadyout.
`timescale 1ns/100ps
module test_spt_timer;
    logic        sys_clk, rst, hsel, hwrite;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, rd, v;
    wire  [31:0] hrdata;
    wire         hreadyout, hresp, listen_on, ref_tick, phase_end;
    int          num_errors, cmp_count, cyc, n;

    spt_timer uut (.sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .listen_on(listen_on),
        .ref_tick(ref_tick), .phase_end(phase_end));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 80000) begin
            num_errors++;
            close_out();
        end
    end
    task close_out;
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {22'h0, idx, 2'b00};
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    // Expected phase length in clock cycles
    function int ticks(input int cnt, input int div);
        return (cnt == 0 ? 16384 : cnt) * 64 * (div == 0 ? 256 : div);
    endfunction
    task gap(output int c);
        c = 0;
        do begin
            @(posedge sys_clk);
            c++;
        end while (phase_end !== 1'b1);
    endtask
    // First phase may be partial, so skip it, then time listen and sleep
    task run(input logic [7:0] ctl, input int cl, input int cs, input int div);
        bus(1'b1, 8'ha0, 32'h0);
        bus(1'b1, 8'h99, div);
        bus(1'b1, 8'ha0, ctl);
        gap(n);
        chk("listen on", 32'h1, {31'h0, listen_on});
        gap(n);
        chk("listen length", ticks(cl, div), n);
        chk("listen off", 32'h0, {31'h0, listen_on});
        gap(n);
        chk("sleep length", ticks(cs, div), n);
    endtask

    initial begin
        rst = 1'b1;
        hsel = 1'b0;
        hwrite = 1'b0;
        htrans = 2'b00;
        haddr = 32'h0;
        hwdata = 32'h0;
        void'($urandom(32'h01586ed6));
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        for (int i = 8'h9a; i <= 8'h9f; i++) begin
            bus(1'b0, i, 32'h0);
            chk("reset value", {31'h0, ~i[0]}, rd);
        end
        bus(1'b1, 8'ha5, 32'hff);
        bus(1'b0, 8'ha5, 32'h0);
        chk("unmapped", 32'h0, rd);
        for (int i = 8'h9a; i <= 8'h9f; i++) begin
            v = $urandom;
            bus(1'b1, i, v);
            bus(1'b0, i, 32'h0);
            chk("readback", i[0] ? {26'h0, v[5:0]} : {24'h0, v[7:0]}, rd);
        end
        bus(1'b1, 8'h9a, 32'h3);
        bus(1'b1, 8'h9b, 32'h0);
        bus(1'b1, 8'h9c, 32'h2);
        bus(1'b1, 8'h9d, 32'h0);
        bus(1'b1, 8'h9e, 32'h0);
        bus(1'b1, 8'h9f, 32'h1);
        run(8'h01, 2, 3, 1);
        run(8'h01, 2, 3, 2);
        run(8'h03, 256, 3, 1);
        v = 1 + $urandom % 30;
        bus(1'b1, 8'h9c, v);
        run(8'h01, v, 3, 1);
        // Zero sleep count loads the full 16384-tick phase
        bus(1'b1, 8'ha0, 32'h0);
        bus(1'b1, 8'h9a, 32'h1);
        bus(1'b1, 8'h9c, 32'h1);
        bus(1'b1, 8'ha0, 32'h1);
        gap(n);
        bus(1'b1, 8'h9a, 32'h0);
        gap(n);
        bus(1'b0, 8'ha1, 32'h0);
        chk("sleep zero", {15'h0, 2'd1, 15'd16384}, rd);
        // Zero listen count, config A then config B
        bus(1'b1, 8'ha0, 32'h0);
        bus(1'b1, 8'h9a, 32'h1);
        bus(1'b1, 8'h9c, 32'h0);
        bus(1'b1, 8'ha0, 32'h1);
        gap(n);
        bus(1'b0, 8'ha1, 32'h0);
        chk("listen zero a", {15'h0, 2'd2, 15'd16384}, rd);
        bus(1'b1, 8'ha0, 32'h0);
        bus(1'b1, 8'h9f, 32'h0);
        bus(1'b1, 8'ha0, 32'h3);
        gap(n);
        bus(1'b0, 8'ha1, 32'h0);
        chk("listen zero b", {15'h0, 2'd2, 15'd16384}, rd);
        // Divider value zero stretches the tick by 256
        bus(1'b1, 8'h99, 32'h0);
        do @(posedge sys_clk); while (ref_tick !== 1'b1);
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (ref_tick !== 1'b1);
        chk("tick period", ticks(1, 0), n);
        close_out();
    end
endmodule // test_spt_timer

bind spt_timer spt_timer_asserts #(.CW(CW)) chk_i (.sys_clk(sys_clk), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .listen_on(listen_on), .ref_tick(ref_tick), .phase_end(phase_end));
